//--- verilog/bmp_top.sv
// Purpose: motor protection state that overrides the Hall gate pattern
// Assumes: APB slave, 100 MHz pclk, events are same-clock pulses or levels
// Notes: zero wait states; latched pause causes cleared by software
//
// What this block does
// [RQ1] Five protection sources: pause edge, fault level, stall, overcurrent, software; the code also protects on current limit.
// [RQ2] While protecting, drive brake or free-run pattern chosen by select bit.
// [RQ3] Fault-mode source protects while active, releases when it goes inactive.
// [RQ4] Pause-mode source latches protection until software clears it.
// [RQ5] Fault pin low with its enable set asserts protection.
// [RQ6] Fault pin enable is bit 0 of the enable register.
// [RQ7] Pause pin edge trigger, enabled by bit 1 of the enable register.
// [RQ8] Pause edge select: 00 off, 01 rise, 10 fall, 11 both.
// [RQ9] Without protection the Hall gate pattern passes unchanged.
// [RQ10] Software protect enable is bit 6 of the enable register.
// [RQ11] Software protect value is bit 7 and applies while bit 6 set.
// [RQ12] Current-limit event protects only when bit 2 is set.
// [RQ13] Current-limit pause mode restarts drive at next PWM cycle start.
// [RQ14] Overcurrent event protects only when bit 3 is set.
// [RQ15] Overcurrent mode select: 0 fault mode, 1 pause mode.
// [RQ16] After overcurrent fault shutdown software restarts the PWM itself.
// [RQ17] Stall compare event protects only when bit 4 is set.
// [RQ18] Stall compare mode select: 0 fault mode, 1 pause mode.
// [RQ19] Stall overflow event protects only when bit 5 is set.
// [RQ20] Stall overflow mode select: 0 fault mode, 1 pause mode.
// [RQ21] Capture timer raises compare or overflow event on abnormal speed.
// [RQ22] Software routes converter to current amplifier before using limit.
// [RQ23] Software keeps current limit off if overcurrent at startup.
// [RQ24] Protection is the OR of all enabled hardware sources.
// [RQ25] All enable and data bits clear to 0 at reset.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module bmp_top
  import bmp_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic fault_n,
  input wire logic pause_pin,
  // Events from converters and capture timer
  input wire bmp_evt_t evt,
  input wire logic pwm_cycle_start,
  // Gate drive
  input wire logic [5:0] hall_gate,
  output logic [5:0] gate_out,
  output logic protect
);
  logic [7:0] enable_q;
  logic [6:0] mode_q;
  logic cfg_q;
  logic [4:0] latch_q;
  logic [4:0] latch_d;
  logic f1_q;
  logic f2_q;
  logic pause_hit;
  logic wr;
  logic rd;
  logic clr_wr;
  logic [4:0] clr_mask;
  logic [4:0] trig;
  logic [4:0] is_pause;
  logic [4:0] en_src;
  logic fault_lvl;
  logic prot_d;

  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;
  assign clr_wr = wr && (paddr == BMP_CLEAR_OFS);
  assign clr_mask = clr_wr ? pwdata[4:0] : 5'h00;

  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= BMP_ENABLE_RST; // [RQ25]
      mode_q <= BMP_MODE_RST[6:0]; // [RQ25]
      cfg_q <= BMP_CFG_RST;
    end else if (wr) begin
      case (paddr)
        BMP_ENABLE_OFS: enable_q <= pwdata[7:0];
        BMP_MODE_OFS: mode_q <= pwdata[6:0];
        BMP_CFG_OFS: cfg_q <= pwdata[BMP_CFG_FREERUN];
        default: ;
      endcase
    end
  end

  // Read data, registered in setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd) begin
      case (paddr)
        BMP_ENABLE_OFS: prdata <= {24'h00_0000, enable_q};
        BMP_MODE_OFS: prdata <= {25'h000_0000, mode_q};
        BMP_CFG_OFS: prdata <= {31'h0000_0000, cfg_q};
        BMP_STATUS_OFS: prdata <= {24'h00_0000, protect, 2'h0, latch_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Zero wait states, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr > BMP_CLEAR_OFS || paddr[1:0] != 2'h0);
    end
  end

  // Fault pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f1_q <= 1'b1;
      f2_q <= 1'b1;
    end else begin
      f1_q <= fault_n;
      f2_q <= f1_q;
    end
  end

  bmp_edge u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin(pause_pin),
    .sel(mode_q[BMP_MD_EDGE_LO +: 2]),
    .hit(pause_hit)
  );

  // Sources: 0 pause pin, 1 current limit, 2 overcurrent, 3 stall cmp, 4 stall ovf
  assign trig = {evt.sovf, evt.scmp, evt.ocur, evt.clim, pause_hit}; // [RQ1] [RQ21]
  assign en_src = {enable_q[BMP_EN_SOVF], enable_q[BMP_EN_SCMP], // [RQ17] [RQ19]
                   enable_q[BMP_EN_OCUR], enable_q[BMP_EN_CLIM], // [RQ12] [RQ14]
                   enable_q[BMP_EN_PAUSE]}; // [RQ7]
  assign is_pause = {mode_q[BMP_MD_SOVF], mode_q[BMP_MD_SCMP], // [RQ18] [RQ20]
                     mode_q[BMP_MD_OCUR], mode_q[BMP_MD_CLIM], 1'b1}; // [RQ15]
  assign fault_lvl = ~f2_q & enable_q[BMP_EN_FAULT]; // [RQ5] [RQ6]

  // Latched pause-mode causes; set wins over clear
  always_comb begin
    latch_d = latch_q & ~clr_mask; // [RQ4]
    if (mode_q[BMP_MD_CLIM] && pwm_cycle_start) begin
      latch_d[1] = 1'b0; // [RQ13]
    end
    latch_d = latch_d | (trig & en_src & is_pause); // [RQ4]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= 5'h00;
    end else begin
      latch_q <= latch_d;
    end
  end

  always_comb begin
    prot_d = fault_lvl | (|latch_q) | (|(trig & en_src & ~is_pause)); // [RQ3] [RQ24]
    if (enable_q[BMP_EN_SWE]) begin
      prot_d = enable_q[BMP_EN_SWD]; // [RQ10] [RQ11]
    end
  end

  // Gate output stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protect <= 1'b0;
      gate_out <= BMP_GATE_FREE;
    end else begin
      protect <= prot_d;
      if (!prot_d) begin
        gate_out <= hall_gate; // [RQ9]
      end else if (cfg_q) begin
        gate_out <= BMP_GATE_FREE; // [RQ2]
      end else begin
        gate_out <= BMP_GATE_BRAKE; // [RQ2]
      end
    end
  end

  property p_gate_pass;
    @(posedge pclk) disable iff (!presetn)
      !prot_d |=> gate_out == $past(hall_gate);
  endproperty
  a_gate_pass: assert property (p_gate_pass) else $error("gate not passed"); // [RQ9]

  property p_brake;
    @(posedge pclk) disable iff (!presetn)
      prot_d && !cfg_q |=> gate_out == BMP_GATE_BRAKE;
  endproperty
  a_brake: assert property (p_brake) else $error("brake pattern wrong"); // [RQ2]

  property p_free;
    @(posedge pclk) disable iff (!presetn)
      prot_d && cfg_q |=> gate_out == BMP_GATE_FREE;
  endproperty
  a_free: assert property (p_free) else $error("free pattern wrong"); // [RQ2]

  property p_fault_pin;
    @(posedge pclk) disable iff (!presetn)
      !f2_q && enable_q[BMP_EN_FAULT] && !enable_q[BMP_EN_SWE] |=> protect;
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault pin ignored"); // [RQ5]

  property p_sw;
    @(posedge pclk) disable iff (!presetn)
      enable_q[BMP_EN_SWE] |=> protect == $past(enable_q[BMP_EN_SWD]);
  endproperty
  a_sw: assert property (p_sw) else $error("software value not applied"); // [RQ11]

  property p_pause_hold;
    @(posedge pclk) disable iff (!presetn)
      latch_q[0] && !clr_wr |=> latch_q[0];
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("pause latch lost"); // [RQ4]

  property p_ocur_fault;
    @(posedge pclk) disable iff (!presetn)
      evt.ocur && enable_q[BMP_EN_OCUR] && !mode_q[BMP_MD_OCUR] && !enable_q[BMP_EN_SWE]
      |=> protect;
  endproperty
  a_ocur_fault: assert property (p_ocur_fault) else $error("overcurrent missed"); // [RQ14]

  property p_disabled;
    @(posedge pclk) disable iff (!presetn)
      enable_q[5:0] == 6'h00 && latch_q == 5'h00 && !enable_q[BMP_EN_SWE] |=> !protect;
  endproperty
  a_disabled: assert property (p_disabled) else $error("protect without source"); // [RQ24]

  property p_clim_restart;
    @(posedge pclk) disable iff (!presetn)
      latch_q[1] && pwm_cycle_start && mode_q[BMP_MD_CLIM] && !evt.clim |=> !latch_q[1];
  endproperty
  a_clim_restart: assert property (p_clim_restart) else $error("no restart"); // [RQ13]

  property p_apb;
    @(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready;
  endproperty
  a_apb: assert property (p_apb) else $error("apb not ready");

  property p_pause_set;
    @(posedge pclk) disable iff (!presetn)
      pause_hit && enable_q[BMP_EN_PAUSE] |=> latch_q[0];
  endproperty
  a_pause_set: assert property (p_pause_set) else $error("pause edge not latched"); // [RQ7]

  property p_edge_off;
    @(posedge pclk) disable iff (!presetn)
      mode_q[BMP_MD_EDGE_LO +: 2] == BMP_EDGE_OFF |-> !pause_hit;
  endproperty
  a_edge_off: assert property (p_edge_off) else $error("edge seen with select off"); // [RQ8]

  property p_clim_off;
    @(posedge pclk) disable iff (!presetn)
      !latch_q[1] && !enable_q[BMP_EN_CLIM] |=> !latch_q[1];
  endproperty
  a_clim_off: assert property (p_clim_off) else $error("limit latched while off"); // [RQ12]

  property p_ocur_off;
    @(posedge pclk) disable iff (!presetn)
      !latch_q[2] && !enable_q[BMP_EN_OCUR] |=> !latch_q[2];
  endproperty
  a_ocur_off: assert property (p_ocur_off) else $error("overcurrent latched while off"); // [RQ14]

  property p_scmp_off;
    @(posedge pclk) disable iff (!presetn)
      !latch_q[3] && !enable_q[BMP_EN_SCMP] |=> !latch_q[3];
  endproperty
  a_scmp_off: assert property (p_scmp_off) else $error("compare latched while off"); // [RQ17]

  property p_sovf_off;
    @(posedge pclk) disable iff (!presetn)
      !latch_q[4] && !enable_q[BMP_EN_SOVF] |=> !latch_q[4];
  endproperty
  a_sovf_off: assert property (p_sovf_off) else $error("overflow latched while off"); // [RQ19]

  property p_clim_fault;
    @(posedge pclk) disable iff (!presetn)
      evt.clim && enable_q[BMP_EN_CLIM] && !mode_q[BMP_MD_CLIM] && !enable_q[BMP_EN_SWE]
      |=> protect;
  endproperty
  a_clim_fault: assert property (p_clim_fault) else $error("current limit missed"); // [RQ12]

  property p_scmp_fault;
    @(posedge pclk) disable iff (!presetn)
      evt.scmp && enable_q[BMP_EN_SCMP] && !mode_q[BMP_MD_SCMP] && !enable_q[BMP_EN_SWE]
      |=> protect;
  endproperty
  a_scmp_fault: assert property (p_scmp_fault) else $error("stall compare missed"); // [RQ17]

  property p_sovf_fault;
    @(posedge pclk) disable iff (!presetn)
      evt.sovf && enable_q[BMP_EN_SOVF] && !mode_q[BMP_MD_SOVF] && !enable_q[BMP_EN_SWE]
      |=> protect;
  endproperty
  a_sovf_fault: assert property (p_sovf_fault) else $error("stall overflow missed"); // [RQ19]

  property p_ocur_pause;
    @(posedge pclk) disable iff (!presetn)
      evt.ocur && enable_q[BMP_EN_OCUR] && mode_q[BMP_MD_OCUR] |=> latch_q[2];
  endproperty
  a_ocur_pause: assert property (p_ocur_pause) else $error("overcurrent not latched"); // [RQ15]

  property p_scmp_pause;
    @(posedge pclk) disable iff (!presetn)
      evt.scmp && enable_q[BMP_EN_SCMP] && mode_q[BMP_MD_SCMP] |=> latch_q[3];
  endproperty
  a_scmp_pause: assert property (p_scmp_pause) else $error("compare not latched"); // [RQ18]

  property p_sovf_pause;
    @(posedge pclk) disable iff (!presetn)
      evt.sovf && enable_q[BMP_EN_SOVF] && mode_q[BMP_MD_SOVF] |=> latch_q[4];
  endproperty
  a_sovf_pause: assert property (p_sovf_pause) else $error("overflow not latched"); // [RQ20]

  property p_fault_release;
    @(posedge pclk) disable iff (!presetn)
      f2_q && latch_q == 5'h00 && !(|(trig & en_src & ~is_pause)) && !enable_q[BMP_EN_SWE]
      |=> !protect;
  endproperty
  a_fault_release: assert property (p_fault_release) else $error("protect not released"); // [RQ3]

  property p_latch_clear;
    @(posedge pclk) disable iff (!presetn)
      clr_wr && pwdata[0] && !(pause_hit && enable_q[BMP_EN_PAUSE]) |=> !latch_q[0];
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("pause latch not cleared"); // [RQ4]

  property p_sw_zero;
    @(posedge pclk) disable iff (!presetn)
      enable_q[BMP_EN_SWE] && !enable_q[BMP_EN_SWD] |=> !protect;
  endproperty
  a_sw_zero: assert property (p_sw_zero) else $error("software release ignored"); // [RQ10]

  c_brake: cover property (@(posedge pclk) disable iff (!presetn)
    protect && gate_out == BMP_GATE_BRAKE);
  c_pause: cover property (@(posedge pclk) disable iff (!presetn) latch_q[0]);
  c_clear: cover property (@(posedge pclk) disable iff (!presetn) latch_q[0] ##1 !latch_q[0]);
  c_free: cover property (@(posedge pclk) disable iff (!presetn)
    protect && gate_out == BMP_GATE_FREE);
  c_sw: cover property (@(posedge pclk) disable iff (!presetn)
    enable_q[BMP_EN_SWE] && protect);
endmodule

//--- verilog/bmp_pkg.sv
// Purpose: shared constants and types of the motor protection block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: offsets are byte addresses
package bmp_pkg;
  // Register byte offsets
  localparam logic [7:0] BMP_ENABLE_OFS = 8'h00;
  localparam logic [7:0] BMP_MODE_OFS = 8'h04;
  localparam logic [7:0] BMP_CFG_OFS = 8'h08;
  localparam logic [7:0] BMP_STATUS_OFS = 8'h0C;
  localparam logic [7:0] BMP_CLEAR_OFS = 8'h10;
  // Enable register fields
  localparam int BMP_EN_FAULT = 0;
  localparam int BMP_EN_PAUSE = 1;
  localparam int BMP_EN_CLIM = 2;
  localparam int BMP_EN_OCUR = 3;
  localparam int BMP_EN_SCMP = 4;
  localparam int BMP_EN_SOVF = 5;
  localparam int BMP_EN_SWE = 6;
  localparam int BMP_EN_SWD = 7;
  // Mode register fields
  localparam int BMP_MD_SOVF = 0;
  localparam int BMP_MD_SCMP = 1;
  localparam int BMP_MD_OCUR = 2;
  localparam int BMP_MD_CLIM = 3;
  localparam int BMP_MD_SW = 4;
  localparam int BMP_MD_EDGE_LO = 5;
  // Config register field
  localparam int BMP_CFG_FREERUN = 0;
  // Reset values
  localparam logic [7:0] BMP_ENABLE_RST = 8'h00;
  localparam logic [7:0] BMP_MODE_RST = 8'h00;
  localparam logic BMP_CFG_RST = 1'b0;
  // Pause edge codes
  localparam logic [1:0] BMP_EDGE_OFF = 2'h0;
  localparam logic [1:0] BMP_EDGE_RISE = 2'h1;
  localparam logic [1:0] BMP_EDGE_FALL = 2'h2;
  localparam logic [1:0] BMP_EDGE_BOTH = 2'h3;
  // Gate pattern: bit5 A top .. bit0 C bottom
  localparam logic [5:0] BMP_GATE_BRAKE = 6'h15;
  localparam logic [5:0] BMP_GATE_FREE = 6'h00;

  typedef struct packed {
    logic clim;
    logic ocur;
    logic scmp;
    logic sovf;
  } bmp_evt_t;
endpackage

//--- verilog/bmp_edge.sv
// Purpose: synchronise the pause pin and detect the selected edge
// Assumes: pin is asynchronous to pclk
// Notes: first sync flop feeds only the second
`timescale 1ns/1ns
module bmp_edge
  import bmp_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin and select
  input wire logic pin,
  input wire logic [1:0] sel,
  // Result
  output logic hit
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_comb begin
    case (sel)
      BMP_EDGE_RISE: hit = s2_q & ~s3_q; // [RQ8]
      BMP_EDGE_FALL: hit = ~s2_q & s3_q; // [RQ8]
      BMP_EDGE_BOTH: hit = s2_q ^ s3_q; // [RQ8]
      default: hit = 1'b0; // [RQ8]
    endcase
  end
endmodule

//--- dv/bmp_pin_model.sv
// Purpose: pin model of the external fault and pause sensing circuit
// Assumes: bench requests change just after pclk rising edges
// Notes: fault line idles high, as a pulled-up open-drain output does
`timescale 1ns/1ns
module bmp_pin_model (
  // Clock
  input wire logic pclk,
  // Requests from the bench
  input wire logic fault_on,
  input wire logic pause_lvl,
  // Pins
  output logic fault_n,
  output logic pause_pin
);
  initial begin
    fault_n = 1'b1;
    pause_pin = 1'b0;
  end
  // Active-low fault level, plain pause level
  always @(posedge pclk) begin
    fault_n <= ~fault_on;
    pause_pin <= pause_lvl;
  end
endmodule

//--- dv/tb_top.sv
// Purpose: self-checking bench of the motor protection block
// Assumes: zero-wait APB slave, pins synchronised in a few cycles
// Notes: waits after pin changes cover the synchroniser delay
`timescale 1ns/1ns
module tb_top
  import bmp_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pwm_cycle_start, fault_on, pause_lvl;
  logic pready, pslverr, fault_n, pause_pin, protect, se, free_sel;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] hall_gate, gate_out;
  bmp_evt_t evt;
  int err_count, checked;
  int cyc = 0;

  bmp_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fault_n(fault_n), .pause_pin(pause_pin), .evt(evt),
    .pwm_cycle_start(pwm_cycle_start), .hall_gate(hall_gate), .gate_out(gate_out),
    .protect(protect));
  bmp_pin_model u_pin (.pclk(pclk), .fault_on(fault_on), .pause_lvl(pause_lvl),
    .fault_n(fault_n), .pause_pin(pause_pin));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task end_of_test();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      end_of_test();
    end
  end

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked = checked + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask

  // One APB transfer, then one idle edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask

  task cw(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Protection state and the gate pattern it implies
  task prot(input string nm, input logic p);
    chk(nm, {31'h0, p}, {31'h0, protect});
    chk("gate_out", {26'h0, p ? (free_sel ? BMP_GATE_FREE : BMP_GATE_BRAKE) : hall_gate},
      {26'h0, gate_out});
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pwm_cycle_start = 1'b0;
    fault_on = 1'b0;
    pause_lvl = 1'b0;
    hall_gate = 6'h2A;
    evt = '0;
    free_sel = 1'b0;
    err_count = 0;
    checked = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk("enable", BMP_ENABLE_OFS, 32'h0);
    rdchk("mode", BMP_MODE_OFS, 32'h0);
    rdchk("cfg", BMP_CFG_OFS, 32'h0);
    prot("pass", 1'b0);
    wr(8'h14, 32'hFF);
    chk("pslverr", 32'h1, {31'h0, se});
    rdchk("unmapped", 8'h14, 32'h0);
    rdchk("enable", BMP_ENABLE_OFS, 32'h0);
    // Fault pin level
    fault_on <= 1'b1;
    cw(6);
    prot("fault_dis", 1'b0);
    wr(BMP_ENABLE_OFS, 32'h1);
    chk("pslverr", 32'h0, {31'h0, se});
    cw(2);
    prot("fault_on", 1'b1);
    wr(BMP_CFG_OFS, 32'h1);
    free_sel = 1'b1;
    cw(2);
    prot("free_run", 1'b1);
    wr(BMP_CFG_OFS, 32'h0);
    free_sel = 1'b0;
    fault_on <= 1'b0;
    cw(6);
    prot("fault_rel", 1'b0);
    // Converter and capture events, fault then pause mode
    for (int e = 0; e < 4; e++) begin
      wr(BMP_ENABLE_OFS, 32'h0);
      wr(BMP_MODE_OFS, 32'h0);
      evt <= bmp_evt_t'(4'h1 << e);
      cw(3);
      prot("evt_dis", 1'b0);
      wr(BMP_ENABLE_OFS, 32'h1 << (5 - e));
      cw(2);
      prot("evt_flt", 1'b1);
      evt <= '0;
      cw(3);
      prot("evt_rel", 1'b0);
      wr(BMP_MODE_OFS, 32'h1 << e);
      evt <= bmp_evt_t'(4'h1 << e);
      @(posedge pclk);
      evt <= '0;
      cw(3);
      prot("evt_latch", 1'b1);
      rdchk("status", BMP_STATUS_OFS, (32'h1 << (4 - e)) | 32'h80);
      if (e == 3) begin
        pwm_cycle_start <= 1'b1;
        @(posedge pclk);
        pwm_cycle_start <= 1'b0;
      end else begin
        wr(BMP_CLEAR_OFS, 32'h1 << (4 - e));
      end
      cw(3);
      prot("evt_clr", 1'b0);
    end
    // Pause pin under every edge code
    wr(BMP_ENABLE_OFS, 32'h2);
    for (int c = 0; c < 4; c++) begin
      wr(BMP_MODE_OFS, 32'(c) << 5);
      pause_lvl <= 1'b1;
      cw(6);
      prot("rise", c[0]);
      wr(BMP_CLEAR_OFS, 32'h1);
      cw(2);
      pause_lvl <= 1'b0;
      cw(6);
      prot("fall", c[1]);
      wr(BMP_CLEAR_OFS, 32'h1);
      cw(2);
    end
    // Software override
    wr(BMP_MODE_OFS, 32'h0);
    wr(BMP_ENABLE_OFS, 32'hC0);
    cw(2);
    prot("sw_on", 1'b1);
    evt <= bmp_evt_t'(4'hF);
    wr(BMP_ENABLE_OFS, 32'h7C);
    cw(2);
    prot("sw_off", 1'b0);
    wr(BMP_ENABLE_OFS, 32'h3C);
    cw(2);
    prot("hw_or", 1'b1);
    evt <= '0;
    rdchk("enable", BMP_ENABLE_OFS, 32'h3C);
    end_of_test();
  end
endmodule
